// File: soc_map.svh
`ifndef SOC_MAP_SVH
`define SOC_MAP_SVH
`define SOC_OFS_CTRL 12'h000
`define SOC_OFS_TRAVERSE 12'h004
`define SOC_OFS_SYNC_WAIT 12'h008
`define SOC_OFS_CLOSE_PULSE 12'h00C
`define SOC_OFS_OPEN_PULSE 12'h010
`define SOC_OFS_TERM 12'h014
`define SOC_OFS_FINAL_TRIP 12'h018
`define SOC_OFS_STATUS 12'h01C
`define SOC_OFS_STATS_CTRL 12'h020
`define SOC_OFS_CNT_BASE 12'h024
`define SOC_CTRL_TYPE_LSB 0
`define SOC_CTRL_SYNC_BIT 2
`define SOC_CTRL_READY_LSB 3
`define SOC_CTRL_LEVEL_LSB 5
`define SOC_STATS_CLEAR_BIT 0
`define SOC_RST_CTRL 7'h41
`define SOC_STEP_MS 20
`define SOC_CLK_KHZ 40000
`define SOC_TICK_CYCLES (`SOC_CLK_KHZ * `SOC_STEP_MS)
`define SOC_RST_TRAVERSE 16'h000A
`define SOC_RST_SYNC_WAIT 16'h000A
`define SOC_RST_CLOSE_PULSE 16'h000A
`define SOC_RST_OPEN_PULSE 16'h000A
`define SOC_RST_TERM 16'h01F4
`define SOC_RST_FINAL_TRIP 16'h000A
`endif

// File: soc_pkg.sv
package soc_pkg;
  typedef enum logic [1:0] {
    SOC_WITHDRAWABLE, SOC_BREAKER, SOC_SW_DISC, SOC_EARTH
  } soc_type_e;
  typedef enum logic [1:0] {
    SOC_POS_INTERMEDIATE, SOC_POS_OPEN, SOC_POS_CLOSED, SOC_POS_BAD
  } soc_pos_e;
  typedef enum logic [2:0] {
    SOC_CART_INTERMEDIATE, SOC_CART_OUT, SOC_CART_IN, SOC_CART_BAD, SOC_CART_NOT_USED
  } soc_cart_e;
  typedef enum logic [1:0] {
    SOC_READY_OFF, SOC_READY_HIGH, SOC_READY_LOW, SOC_READY_RSVD
  } soc_ready_e;
  typedef enum logic [1:0] {
    SOC_LVL_USER, SOC_LVL_OPERATOR, SOC_LVL_CONFIGURATOR, SOC_LVL_SUPER
  } soc_level_e;
  typedef enum logic [1:0] {
    SOC_ST_IDLE, SOC_ST_SYNC_WAIT, SOC_ST_OPENING, SOC_ST_CLOSING
  } soc_state_e;
  typedef struct packed {
    soc_level_e access_level;
    soc_ready_e ready_mode;
    logic use_sync;
    soc_type_e obj_type;
  } soc_cfg_s;
endpackage : soc_pkg

// File: soc_object_control.sv
// Summary of operation
// - Two 32-bit counters hold failed open and failed close requests, refused or timed out.
// - Clear command zeroes all request counters, then the clear bit returns to zero.
// - Withdrawable breaker: cart and breaker position, control, ready, sync, interlocks.
// - Switching disconnector: position and open/close control only, no checks.
// - Earthing disconnector: position indication only, commands ignored.
// - Both position inputs active beyond traverse time reports bad.
// - Neither position input active beyond traverse time reports intermediate.
// - With sync in use, close waits for sync-ok, cancelled after sync timeout.
// - Close pulse limited to maximum length, ended early once closed.
// - Open pulse limited to maximum length, ended early once open.
// - No state change within termination timeout ends control, raises error event.
// - Final-trip output lasts configured length; zero length holds it while the position stays open.
// - Final trip only when no further automatic reclose is expected.
// - Panel commands accepted only at or above the selected access level.
// - Open and close taken from local, remote and application sources.
// - With sync in use, close without sync-ok goes to sync wait instead of closing.
// - Ready check allows close only when readiness matches selected polarity.
// - Two 32-bit counters hold successful open and close requests.
`timescale 1ns/1ps
`default_nettype none
`include "soc_map.svh"

module soc_pos_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic a,
  input wire logic b,
  input wire logic [15:0] limit,
  output logic [1:0] code
);
  logic [1:0] last;
  logic [15:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 2'h0;
      cnt <= 16'h0000;
    end else if ({b, a} != last) begin
      last <= {b, a};
      cnt <= 16'h0000;
    end else if (tick && cnt != 16'hFFFF) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Undefined pairs are held until the traverse window has run out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= 2'h0;
    end else if (a != b) begin
      code <= {b, a};
    end else if (cnt >= limit && {b, a} == last) begin
      code <= {b, a};
    end
  end
endmodule : soc_pos_filter

module soc_object_control #(
  parameter int TICK_CYCLES = `SOC_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic open_status_in,
  input wire logic close_status_in,
  input wire logic cart_in_input,
  input wire logic cart_pulled_out_input,
  input wire logic ready_input,
  input wire logic sync_ok_input,
  input wire logic local_open,
  input wire logic local_close,
  input wire logic remote_open,
  input wire logic remote_close,
  input wire logic app_open,
  input wire logic app_close,
  input wire logic panel_diagram_open,
  input wire logic panel_diagram_close,
  input wire logic [1:0] panel_user_level,
  input wire logic open_interlock,
  input wire logic close_interlock,
  input wire logic reclose_expected,
  output logic open_command,
  output logic close_command,
  output logic final_trip,
  output logic ctrl_error_event
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  soc_pkg::soc_cfg_s cfg;
  logic [15:0] traverse, sync_wait, close_pulse, open_pulse, term, ft_len;
  logic stats_clear;
  logic [31:0] counts [4];
  logic [3:0] evt;
  logic [9:0] pin_ff1, pin_ff2;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [1:0] pos_code, cart_code;
  soc_pkg::soc_pos_e pos, pos_d;
  soc_pkg::soc_cart_e cart;
  soc_pkg::soc_state_e state;
  logic [15:0] op_ticks, ft_ticks;
  logic open_lvl, close_lvl, open_lvl_d, close_lvl_d;
  logic ft_hold;

  // Pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff1 <= 10'h000;
      pin_ff2 <= 10'h000;
    end else begin
      pin_ff1 <= {remote_close, remote_open, local_close, local_open, sync_ok_input,
                  ready_input, cart_pulled_out_input, cart_in_input, close_status_in,
                  open_status_in};
      pin_ff2 <= pin_ff1;
    end
  end

  wire logic s_open = pin_ff2[0];
  wire logic s_close = pin_ff2[1];
  wire logic s_cart_in = pin_ff2[2];
  wire logic s_cart_out = pin_ff2[3];
  wire logic s_ready = pin_ff2[4];
  wire logic s_sync = pin_ff2[5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TW'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  soc_pos_filter u_breaker_pos (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .a(s_open),
    .b(s_close),
    .limit(traverse),
    .code(pos_code)
  );

  soc_pos_filter u_cart_pos (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .a(s_cart_out),
    .b(s_cart_in),
    .limit(traverse),
    .code(cart_code)
  );

  wire logic is_cb = (cfg.obj_type == soc_pkg::SOC_WITHDRAWABLE) ||
                     (cfg.obj_type == soc_pkg::SOC_BREAKER);
  wire logic can_ctrl = (cfg.obj_type != soc_pkg::SOC_EARTH);
  wire logic sync_used = is_cb && cfg.use_sync;
  wire logic ready_ok = !is_cb || (cfg.ready_mode == soc_pkg::SOC_READY_OFF) ||
                        (cfg.ready_mode == soc_pkg::SOC_READY_RSVD) ||
                        (cfg.ready_mode == soc_pkg::SOC_READY_HIGH && s_ready) ||
                        (cfg.ready_mode == soc_pkg::SOC_READY_LOW && !s_ready);
  wire logic panel_ok = (panel_user_level >= cfg.access_level);

  assign pos = soc_pkg::soc_pos_e'(pos_code);
  assign cart = (cfg.obj_type == soc_pkg::SOC_WITHDRAWABLE) ?
                soc_pkg::soc_cart_e'({1'b0, cart_code}) : soc_pkg::SOC_CART_NOT_USED;

  always_comb begin
    open_lvl = pin_ff2[6] | pin_ff2[8] | app_open | (panel_diagram_open & panel_ok);
    close_lvl = pin_ff2[7] | pin_ff2[9] | app_close | (panel_diagram_close & panel_ok);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_lvl_d <= 1'b0;
      close_lvl_d <= 1'b0;
    end else begin
      open_lvl_d <= open_lvl;
      close_lvl_d <= close_lvl;
    end
  end

  wire logic open_edge = open_lvl && !open_lvl_d;
  wire logic close_edge = close_lvl && !close_lvl_d;

  // Event bits: 0 open ok, 1 close ok, 2 open failed, 3 close failed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= soc_pkg::SOC_ST_IDLE;
      op_ticks <= 16'h0000;
      evt <= 4'h0;
      ctrl_error_event <= 1'b0;
    end else begin
      evt <= 4'h0;
      ctrl_error_event <= 1'b0;
      if (tick && op_ticks != 16'hFFFF) begin
        op_ticks <= op_ticks + 16'h0001;
      end
      case (state)
        soc_pkg::SOC_ST_IDLE: begin
          op_ticks <= 16'h0000;
          if (open_edge && can_ctrl) begin
            if (is_cb && open_interlock) begin
              evt[2] <= 1'b1;
            end else begin
              state <= soc_pkg::SOC_ST_OPENING;
            end
          end else if (close_edge && can_ctrl) begin
            if ((is_cb && close_interlock) || !ready_ok) begin
              evt[3] <= 1'b1;
            end else if (sync_used && !s_sync) begin
              state <= soc_pkg::SOC_ST_SYNC_WAIT;
            end else begin
              state <= soc_pkg::SOC_ST_CLOSING;
            end
          end
        end
        soc_pkg::SOC_ST_SYNC_WAIT: begin
          if (s_sync) begin
            state <= soc_pkg::SOC_ST_CLOSING;
            op_ticks <= 16'h0000;
          end else if (op_ticks >= sync_wait) begin
            state <= soc_pkg::SOC_ST_IDLE;
            evt[3] <= 1'b1;
          end
        end
        soc_pkg::SOC_ST_OPENING: begin
          if (pos == soc_pkg::SOC_POS_OPEN) begin
            state <= soc_pkg::SOC_ST_IDLE;
            evt[0] <= 1'b1;
          end else if (op_ticks >= term) begin
            state <= soc_pkg::SOC_ST_IDLE;
            evt[2] <= 1'b1;
            ctrl_error_event <= 1'b1;
          end
        end
        soc_pkg::SOC_ST_CLOSING: begin
          if (pos == soc_pkg::SOC_POS_CLOSED) begin
            state <= soc_pkg::SOC_ST_IDLE;
            evt[1] <= 1'b1;
          end else if (op_ticks >= term) begin
            state <= soc_pkg::SOC_ST_IDLE;
            evt[3] <= 1'b1;
            ctrl_error_event <= 1'b1;
          end
        end
        default: begin
          state <= soc_pkg::SOC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_command <= 1'b0;
      close_command <= 1'b0;
    end else begin
      open_command <= (state == soc_pkg::SOC_ST_OPENING) && (pos != soc_pkg::SOC_POS_OPEN) &&
                      (op_ticks < open_pulse);
      close_command <= (state == soc_pkg::SOC_ST_CLOSING) && (pos != soc_pkg::SOC_POS_CLOSED) &&
                       (op_ticks < close_pulse);
    end
  end

  // Any closed-to-open transition with no reclose expected counts as a trip, including protection trips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_d <= soc_pkg::SOC_POS_INTERMEDIATE;
      ft_ticks <= 16'h0000;
      ft_hold <= 1'b0;
      final_trip <= 1'b0;
    end else begin
      pos_d <= pos;
      if (pos == soc_pkg::SOC_POS_OPEN && pos_d == soc_pkg::SOC_POS_CLOSED &&
          !reclose_expected) begin
        ft_hold <= 1'b1;
        ft_ticks <= 16'h0000;
      end else if (ft_hold) begin
        if (tick && ft_ticks != 16'hFFFF) begin
          ft_ticks <= ft_ticks + 16'h0001;
        end
        if (ft_len == 16'h0000) begin
          ft_hold <= (pos == soc_pkg::SOC_POS_OPEN);
        end else if (ft_ticks >= ft_len) begin
          ft_hold <= 1'b0;
        end
      end
      final_trip <= ft_hold;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          counts[gi] <= 32'h00000000;
        end else if (stats_clear) begin
          counts[gi] <= 32'h00000000;
        end else if (evt[gi] && counts[gi] != 32'hFFFFFFFF) begin
          counts[gi] <= counts[gi] + 32'h00000001;
        end
      end
    end
  endgenerate

  wire logic wr_en = psel && penable && pready && pwrite;
  wire logic setup = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= soc_pkg::soc_cfg_s'(`SOC_RST_CTRL);
      traverse <= `SOC_RST_TRAVERSE;
      sync_wait <= `SOC_RST_SYNC_WAIT;
      close_pulse <= `SOC_RST_CLOSE_PULSE;
      open_pulse <= `SOC_RST_OPEN_PULSE;
      term <= `SOC_RST_TERM;
      ft_len <= `SOC_RST_FINAL_TRIP;
      stats_clear <= 1'b0;
    end else begin
      // Counters clear in one cycle, so the command drops right after
      stats_clear <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `SOC_OFS_CTRL: cfg <= soc_pkg::soc_cfg_s'(pwdata[6:0]);
          `SOC_OFS_TRAVERSE: traverse <= pwdata[15:0];
          `SOC_OFS_SYNC_WAIT: sync_wait <= pwdata[15:0];
          `SOC_OFS_CLOSE_PULSE: close_pulse <= pwdata[15:0];
          `SOC_OFS_OPEN_PULSE: open_pulse <= pwdata[15:0];
          `SOC_OFS_TERM: term <= pwdata[15:0];
          `SOC_OFS_FINAL_TRIP: ft_len <= pwdata[15:0];
          `SOC_OFS_STATS_CTRL: stats_clear <= pwdata[`SOC_STATS_CLEAR_BIT];
          default: stats_clear <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (setup) begin
        case (paddr)
          `SOC_OFS_CTRL: prdata <= {25'h0, cfg};
          `SOC_OFS_TRAVERSE: prdata <= {16'h0, traverse};
          `SOC_OFS_SYNC_WAIT: prdata <= {16'h0, sync_wait};
          `SOC_OFS_CLOSE_PULSE: prdata <= {16'h0, close_pulse};
          `SOC_OFS_OPEN_PULSE: prdata <= {16'h0, open_pulse};
          `SOC_OFS_TERM: prdata <= {16'h0, term};
          `SOC_OFS_FINAL_TRIP: prdata <= {16'h0, ft_len};
          `SOC_OFS_STATUS: prdata <= {23'h0, state, s_sync, ready_ok, cart, pos};
          `SOC_OFS_STATS_CTRL: prdata <= {31'h0, stats_clear};
          `SOC_OFS_CNT_BASE: prdata <= counts[0];
          `SOC_OFS_CNT_BASE + 12'h004: prdata <= counts[1];
          `SOC_OFS_CNT_BASE + 12'h008: prdata <= counts[2];
          `SOC_OFS_CNT_BASE + 12'h00C: prdata <= counts[3];
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : soc_object_control
`default_nettype wire

// File: soc_object_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module soc_object_control_assertions #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic open_status_in,
  input wire logic close_status_in,
  input wire logic reclose_expected,
  input wire logic open_command,
  input wire logic close_command,
  input wire logic final_trip,
  input wire logic ctrl_error_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] ty;
  // Shadow of the object type, taken from completed CTRL writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ty <= 2'h1;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      ty <= pwdata[1:0];
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_one_command: assert property (!(open_command && close_command))
    else $error("open and close driven together");
  // Slack covers the input synchroniser and the decode register
  a_open_ends: assert property ($rose(open_status_in) && !close_status_in
    |-> ##[1:6] !open_command) else $error("open pulse not ended");
  a_close_ends: assert property ($rose(close_status_in) && !open_status_in
    |-> ##[1:6] !close_command) else $error("close pulse not ended");
  a_error_pulse: assert property (ctrl_error_event |=> !ctrl_error_event)
    else $error("error event longer than one cycle");
  a_trip_reclose: assert property ($rose(final_trip) |-> !$past(reclose_expected, 2))
    else $error("final trip while reclose expected");
  a_earth_quiet: assert property (ty == 2'h3 |-> !open_command && !close_command)
    else $error("command on earth switch");
endmodule : soc_object_control_assertions
bind soc_object_control soc_object_control_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .open_status_in, .close_status_in, .reclose_expected, .open_command,
  .close_command, .final_trip, .ctrl_error_event
);
`default_nettype wire

// File: soc_breaker_model.sv
`timescale 1ns/1ps
`default_nettype none
module soc_breaker_model #(
  parameter int MOVE = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic open_command,
  input wire logic close_command,
  input wire logic stuck,
  input wire logic [1:0] fault,
  output logic open_status_in,
  output logic close_status_in
);
  logic closed;
  logic go;
  int cnt;
  assign go = !stuck && (closed ? open_command : close_command);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed <= 1'b1;
      cnt <= 0;
    end else if (go && cnt == MOVE) begin
      closed <= !closed;
      cnt <= 0;
    end else begin
      cnt <= go ? cnt + 1 : 0;
    end
  end
  // Both contacts drop while the mechanism travels; fault 1 both, 2 neither
  assign open_status_in = fault == 2'h1 || (fault == 2'h0 && !closed && cnt == 0);
  assign close_status_in = fault == 2'h1 || (fault == 2'h0 && closed && cnt == 0);
endmodule : soc_breaker_model
`default_nettype wire

// File: soc_object_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "soc_map.svh"
module soc_object_control_tb;
  localparam int TK = 8;
  localparam int PM = 5;
  localparam logic [11:0] CT = `SOC_OFS_CTRL;
  localparam logic [11:0] ST = `SOC_OFS_STATUS;
  localparam logic [11:0] CB = `SOC_OFS_CNT_BASE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rq;
  logic pready, pslverr, re, open_status_in, close_status_in;
  logic open_command, close_command, final_trip, ctrl_error_event;
  logic ready_input = 1'b1;
  logic sync_ok_input = 1'b0;
  logic reclose_expected = 1'b0;
  logic stuck = 1'b0;
  logic [1:0] fault = 2'h0;
  logic [1:0] panel_user_level = 2'h3;
  logic [6:0] src = 7'h00;
  int mismatches = 0;
  int n_checks = 0;
  int n_op = 0;
  int n_cl = 0;
  int n_er = 0;
  int n_ft = 0;
  int b_op, b_cl, b_er, b_ft;
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_op <= n_op + (open_command === 1'b1);
    n_cl <= n_cl + (close_command === 1'b1);
    n_er <= n_er + (ctrl_error_event === 1'b1);
    n_ft <= n_ft + (final_trip === 1'b1);
  end
  soc_object_control #(.TICK_CYCLES(TK)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .open_status_in, .close_status_in,
    .cart_in_input(1'b1),
    .cart_pulled_out_input(1'b0),
    .ready_input, .sync_ok_input,
    .local_open(src[0]), .remote_open(src[1]), .app_open(src[2]), .app_close(src[3]),
    .remote_close(src[4]), .panel_diagram_open(src[5]), .local_close(src[6]),
    .panel_diagram_close(1'b0), .panel_user_level,
    .open_interlock(1'b0), .close_interlock(1'b0), .reclose_expected,
    .open_command, .close_command, .final_trip, .ctrl_error_event
  );
  soc_breaker_model model (
    .pclk, .presetn, .open_command, .close_command, .stuck, .fault,
    .open_status_in, .close_status_in
  );
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic tmo;
    $display("ERROR %0t: timeout", $time);
    mismatches++;
    report_and_stop();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) tmo();
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) tmo();
  endtask : wait_hi
  // Held for six cycles so the two-flop input synchroniser sees it
  task automatic pulse(input int b);
    @(posedge pclk);
    src[b] <= 1'b1;
    repeat (6) @(posedge pclk);
    src[b] <= 1'b0;
  endtask : pulse
  task automatic snap;
    b_op = n_op;
    b_cl = n_cl;
    b_er = n_er;
    b_ft = n_ft;
  endtask : snap
  task automatic t_reset;
    rd(CT);
    chk(rq, 32'h41);
    rd(`SOC_OFS_TRAVERSE);
    chk(rq, 32'h0A);
    rd(`SOC_OFS_TERM);
    chk(rq, 32'h1F4);
    rd(`SOC_OFS_FINAL_TRIP);
    chk(rq, 32'h0A);
    rd(12'h100);
    chk(re, 1);
    chk(rq, 32'h0);
    apb(1'b1, `SOC_OFS_CLOSE_PULSE, PM);
    apb(1'b1, `SOC_OFS_OPEN_PULSE, PM);
    apb(1'b1, `SOC_OFS_TERM, 32'h8);
    apb(1'b1, `SOC_OFS_SYNC_WAIT, 32'h2);
  endtask : t_reset
  task automatic t_open;
    snap();
    pulse(0);
    wait_hi(open_status_in);
    repeat (120) @(posedge pclk);
    rd(CB);
    chk(rq, 32'h1);
    rd(ST);
    chk(rq[1:0], 2'h1);
    chk(n_op - b_op > 0 && n_op - b_op < PM * TK, 1);
    chk(n_ft - b_ft >= 10 * TK && n_ft - b_ft <= 11 * TK, 1);
  endtask : t_open
  task automatic t_close;
    snap();
    apb(1'b1, CT, 32'h49);
    ready_input <= 1'b0;
    // Let the readiness pin clear its synchroniser first
    repeat (4) @(posedge pclk);
    pulse(4);
    repeat (20) @(posedge pclk);
    rd(CB + 12'hC);
    chk(rq, 32'h1);
    chk(n_cl - b_cl, 0);
    apb(1'b1, CT, 32'h4D);
    ready_input <= 1'b1;
    repeat (4) @(posedge pclk);
    pulse(3);
    repeat (40) @(posedge pclk);
    rd(CB + 12'hC);
    chk(rq, 32'h2);
    chk(n_cl - b_cl, 0);
    sync_ok_input <= 1'b1;
    pulse(6);
    wait_hi(close_status_in);
    repeat (10) @(posedge pclk);
    rd(CB + 12'h4);
    chk(rq, 32'h1);
    rd(ST);
    chk(rq[1:0], 2'h2);
    chk(n_cl - b_cl > 0 && n_cl - b_cl < PM * TK, 1);
  endtask : t_close
  task automatic t_term;
    snap();
    apb(1'b1, CT, 32'h41);
    stuck <= 1'b1;
    pulse(1);
    wait_hi(ctrl_error_event);
    repeat (3) @(posedge pclk);
    chk(n_er - b_er, 1);
    chk(n_op - b_op >= (PM - 1) * TK && n_op - b_op <= PM * TK + 1, 1);
    rd(CB + 12'h8);
    chk(rq, 32'h1);
    stuck <= 1'b0;
  endtask : t_term
  task automatic t_bad;
    fault <= 2'h1;
    repeat (10) @(posedge pclk);
    rd(ST);
    chk(rq[1:0], 2'h2);
    repeat (100) @(posedge pclk);
    rd(ST);
    chk(rq[1:0], 2'h3);
    fault <= 2'h2;
    repeat (100) @(posedge pclk);
    rd(ST);
    chk(rq[1:0], 2'h0);
    fault <= 2'h0;
    repeat (10) @(posedge pclk);
  endtask : t_bad
  task automatic t_types;
    snap();
    apb(1'b1, CT, 32'h43);
    pulse(2);
    repeat (60) @(posedge pclk);
    chk(n_op - b_op, 0);
    rd(ST);
    chk(rq[4:2], 3'h4);
    apb(1'b1, CT, 32'h40);
    rd(ST);
    chk(rq[4:2], 3'h2);
    reclose_expected <= 1'b1;
    panel_user_level <= 2'h1;
    pulse(5);
    repeat (30) @(posedge pclk);
    chk(n_op - b_op, 0);
    panel_user_level <= 2'h3;
    pulse(5);
    wait_hi(open_status_in);
    repeat (120) @(posedge pclk);
    rd(CB);
    chk(rq, 32'h2);
    chk(n_ft - b_ft, 0);
  endtask : t_types
  task automatic t_clear;
    apb(1'b1, `SOC_OFS_STATS_CTRL, 32'h1);
    rd(`SOC_OFS_STATS_CTRL);
    chk(rq, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(CB + 12'(4 * i));
      chk(rq, 32'h0);
    end
  endtask : t_clear
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_open();
    t_close();
    t_term();
    t_bad();
    t_types();
    t_clear();
    report_and_stop();
  end
endmodule : soc_object_control_tb
`default_nettype wire
